// ==== pkg/sdi_defs.vh ====
// constants for the serial diagnostic interface: frame layout, register map, reset values, timing
// Functional notes
// - supply overvoltage sets the supply-over flag and halts gate switching
// - supply undervoltage sets the supply-under flag and halts the device
// - diagnostic write or off mode clears the latched error flags
// - clearing a flag never releases the halted fault state
// - every serial access is checked; an illegal command sets the command-error flag
// - overtemperature sets its flag and halts the device
// - gate supply not good within start-up error time sets fault and halts
// - gate outputs toggle only while gate supply good is set
// - gate supply leaving window after settle, while in range, clears good and halts
// - output window flags change only after the filter time has passed
// - select is active low; serial output floats while select is high
// - input sampled on falling clock edge, output shifted on rising edge
// - frame: bit 15 read/write, bits 14:8 address, bits 7:0 data
// - reply: diagnostic byte high, read data or newly written data low
// - first command after off mode returns all zeros
// - a transaction runs from select falling to select rising
// - any multiple of 16 clocks is accepted for daisy chains
// - a read ignores the data byte and changes nothing
// - clock count not a multiple of 16 drops the write and flags an error
// - illegal accesses modify nothing; next reply carries zero data
// - 128 byte registers; control below 0x40, diagnostics from 0x40
// - diagnostic register at 0x5F with its eight flags
// - configuration registers are writable only in configuration mode
`ifndef SDI_DEFS_VH
`define SDI_DEFS_VH
// ==========================================================
// frame layout
`define SDI_RW_BIT 15
`define SDI_ADDR_HI 14
`define SDI_ADDR_LO 8
`define SDI_DATA_HI 7
`define SDI_CNT_W 4
// ==========================================================
// register map, one bit per address
`define SDI_ADDR_DIAG 7'h5F
`define SDI_CTRL_MAP 128'h0000_0000_0000_0000_0001_8060_1200_01FB
`define SDI_CFG_MAP 128'h0000_0000_0000_0000_0000_0000_0C3F_FE04
`define SDI_RO_MAP 128'h0000_0000_8000_0066_0000_0000_0000_0000
// ==========================================================
// reset values
`define SDI_DIAG_RST 8'h00
`define SDI_SYNC_RST 10'h200
// ==========================================================
// timing; cycle counts are the times at the clock rate, sized to their counters
`define SDI_CLK_MHZ 20
`define SDI_FLT_TIME_NS 10000
`define SDI_FLT_CYC 8'hC8
`define SDI_GATE_SETTLE_TIME_US 1000
`define SDI_GATE_SETTLE_CYC 16'h4E20
`define SDI_GATE_ERR_TIME_US 2000
`define SDI_GATE_ERR_CYC 16'h9C40
`endif

// ==== core/sdi_top.v ====
// serial target interface with diagnostic flag logic
`timescale 1ns/1ns
`include "sdi_defs.vh"

module sdi_top #(
    parameter [15:0] GATE_SETTLE_CYC = `SDI_GATE_SETTLE_CYC,
    parameter [15:0] GATE_ERR_CYC = `SDI_GATE_ERR_CYC
) (
    // clock and reset
    input wire clk_in,
    input wire rst_b_in,
    // serial link
    input wire select_n_in,
    input wire sclk_in,
    input wire sdi_in,
    output wire sdo_out,
    output wire sdo_oe_b_out,
    // raw monitor conditions
    input wire supply_over_in,
    input wire supply_under_in,
    input wire overtemp_in,
    input wire gate_supply_in_window_in,
    input wire gate_supply_in_range_in,
    input wire output_one_raw_in,
    input wire output_two_raw_in,
    // device mode
    input wire off_mode_in,
    input wire config_mode_in,
    // register store
    output wire reg_wr_out,
    output wire [6:0] reg_addr_out,
    output wire [7:0] reg_wdata_out,
    input wire [7:0] reg_rdata_in,
    // status
    output wire halted_out,
    output wire gate_supply_good_out,
    output wire gate_drive_enable_out,
    output wire output_one_in_window_out,
    output wire output_two_in_window_out,
    output wire [7:0] diagnostic_flags_out
);

    localparam [7:0] FLT_CYC = `SDI_FLT_CYC;
    localparam [15:0] ONE16 = 16'h0001;
    // timer counts are in clk_in cycles, so they scale with its rate

    // ==========================================================
    // address decode
    function map_hit;
        input [127:0] map;
        input [6:0] addr;
        begin
            map_hit = map[addr];
        end
    endfunction

    // ==========================================================
    // input synchronisers
    // the serial and monitor pin inputs share one two-stage vector so they keep their relative timing
    reg [9:0] sync1_q;
    reg [9:0] sync2_q;
    reg cs_prev_q;
    reg sclk_prev_q;

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync1_q <= `SDI_SYNC_RST;
            sync2_q <= `SDI_SYNC_RST;
            cs_prev_q <= 1'b1;
            sclk_prev_q <= 1'b0;
        end else begin
            sync1_q <= {select_n_in, sclk_in, sdi_in, supply_over_in, supply_under_in, overtemp_in,
                        gate_supply_in_window_in, gate_supply_in_range_in, output_one_raw_in,
                        output_two_raw_in};
            sync2_q <= sync1_q;
            cs_prev_q <= sync2_q[9];
            sclk_prev_q <= sync2_q[8];
        end
    end

    // every synchronised pin event reaches the logic two clocks late
    wire cs_n = sync2_q[9];
    wire sclk = sync2_q[8];
    wire sdi = sync2_q[7];
    wire raw_ov = sync2_q[6];
    wire raw_uv = sync2_q[5];
    wire raw_ot = sync2_q[4];
    wire raw_gwin = sync2_q[3];
    wire raw_grange = sync2_q[2];
    wire [1:0] raw_win = sync2_q[1:0];

    // serial clock edges count only while select is seen low
    wire cs_fall = cs_prev_q & ~cs_n;
    wire cs_rise = ~cs_prev_q & cs_n;
    wire sclk_rise = ~sclk_prev_q & sclk & ~cs_n;
    wire sclk_fall = sclk_prev_q & ~sclk & ~cs_n;

    // ==========================================================
    // diagnostic flags and state
    // latched error flags
    reg ov_q;
    reg uv_q;
    reg ot_q;
    reg err_q;
    reg gfault_q;

    // gate supply and halt state
    reg ggood_q;
    reg halted_q;
    reg good_seen_q;
    reg [15:0] gt_q;

    // window filters and first-reply marker
    reg [1:0] win_q;
    reg [15:0] fcnt_q;
    reg first_q;

    wire [7:0] diag = {win_q[1], win_q[0], ggood_q, ot_q, uv_q, ov_q, err_q, gfault_q};

    // ==========================================================
    // serial shifter
    // one register both samples and drives, so a chained neighbour sees our input sixteen clocks later in the same frame
    reg [15:0] sh_q;
    reg [`SDI_CNT_W-1:0] cnt_q;
    reg seen_q;
    reg sdo_q;
    reg [7:0] resp_q;
    reg resp_diag_q;

    // a read of the diagnostic address returns the live flags, not a snapshot
    wire [7:0] reply_data = resp_diag_q ? diag : resp_q;
    wire [15:0] reply = first_q ? 16'h0000 : {diag, reply_data};

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sh_q <= 16'h0000;
            cnt_q <= {`SDI_CNT_W{1'b0}};
            seen_q <= 1'b0;
            sdo_q <= 1'b0;
        end else if (cs_fall) begin
            sh_q <= reply;
            sdo_q <= reply[15];
            cnt_q <= {`SDI_CNT_W{1'b0}};
            seen_q <= 1'b0;
        end else if (sclk_rise) begin
            sdo_q <= sh_q[15];
        end else if (sclk_fall) begin
            sh_q <= {sh_q[14:0], sdi};
            cnt_q <= cnt_q + {{(`SDI_CNT_W-1){1'b0}}, 1'b1};
            seen_q <= 1'b1;
        end
    end

    assign sdo_out = sdo_q;
    assign sdo_oe_b_out = cs_n;

    // ==========================================================
    // command execution, one cycle after select rises
    reg exec_q;
    reg len_ok_q;
    reg [15:0] cmd_q;

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            exec_q <= 1'b0;
            len_ok_q <= 1'b0;
            cmd_q <= 16'h0000;
        end else begin
            exec_q <= cs_rise;
            if (cs_rise) begin
                cmd_q <= sh_q;
                len_ok_q <= seen_q & (cnt_q == {`SDI_CNT_W{1'b0}});
            end
        end
    end

    // config mode is read in the execute cycle, so it may change during the frame
    wire is_read = cmd_q[`SDI_RW_BIT];
    wire [6:0] addr = cmd_q[`SDI_ADDR_HI:`SDI_ADDR_LO];
    wire is_diag = (addr == `SDI_ADDR_DIAG);

    // address classes
    wire hit_ctrl = map_hit(`SDI_CTRL_MAP, addr);
    wire hit_cfg = map_hit(`SDI_CFG_MAP, addr);
    wire hit_ro = map_hit(`SDI_RO_MAP, addr);
    wire rd_ok = hit_ctrl | hit_cfg | hit_ro;
    wire wr_ok = hit_ctrl | (hit_cfg & config_mode_in) | is_diag;
    wire legal = len_ok_q & (is_read ? rd_ok : wr_ok);
    wire cmd_err = exec_q & ~legal;
    wire diag_wr = exec_q & legal & ~is_read & is_diag;

    assign reg_wr_out = exec_q & legal & ~is_read & ~is_diag;
    assign reg_addr_out = addr;
    assign reg_wdata_out = cmd_q[`SDI_DATA_HI:0];

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            resp_q <= 8'h00;
            resp_diag_q <= 1'b0;
        end else if (exec_q) begin
            if (!legal) begin
                resp_q <= 8'h00;
                resp_diag_q <= 1'b0;
            end else if (is_diag) begin
                resp_q <= 8'h00;
                resp_diag_q <= 1'b1;
            end else begin
                resp_q <= is_read ? reg_rdata_in : cmd_q[`SDI_DATA_HI:0];
                resp_diag_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // gate supply supervision
    wire clr = diag_wr | off_mode_in;
    wire settled = (gt_q >= GATE_SETTLE_CYC);
    wire gate_err_evt = ~off_mode_in & (gt_q == GATE_ERR_CYC - ONE16) & ~good_seen_q & ~raw_gwin;
    wire gate_lost_evt = ~off_mode_in & settled & ggood_q & ~raw_gwin & raw_grange;
    wire fault_evt = raw_ov | raw_uv | raw_ot | gate_err_evt | gate_lost_evt;

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            gt_q <= 16'h0000;
            good_seen_q <= 1'b0;
            ggood_q <= 1'b0;
        end else begin
            // the timer saturates at the error time, so the fault fires once per start
            if (off_mode_in) begin
                gt_q <= 16'h0000;
            end else if (gt_q != GATE_ERR_CYC) begin
                gt_q <= gt_q + ONE16;
            end
            good_seen_q <= ~off_mode_in & (good_seen_q | raw_gwin);
            // a halt of any cause drops good, which also stops the gates
            ggood_q <= ~off_mode_in & ~halted_q & ~gate_lost_evt & raw_gwin;
        end
    end

    assign gate_drive_enable_out = ggood_q & ~halted_q;

    // ==========================================================
    // latched flags; a set in the clearing cycle wins
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ov_q <= 1'b0;
            uv_q <= 1'b0;
            ot_q <= 1'b0;
            err_q <= 1'b0;
            gfault_q <= 1'b0;
            halted_q <= 1'b0;
            first_q <= 1'b1;
        end else begin
            ov_q <= (ov_q & ~clr) | raw_ov;
            uv_q <= (uv_q & ~clr) | raw_uv;
            ot_q <= (ot_q & ~clr) | raw_ot;
            err_q <= (err_q & ~clr) | cmd_err;
            gfault_q <= (gfault_q & ~clr) | gate_err_evt;
            // only off mode ends the halt, flag clearing does not
            halted_q <= (halted_q & ~off_mode_in) | fault_evt;
            // off mode is a level: every cycle spent in it restarts the first-reply rule
            if (off_mode_in) begin
                first_q <= 1'b1;
            end else if (cs_fall) begin
                first_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // output window filters
    // a glitch shorter than the filter restarts the count, so fast ripple never toggles a flag
    integer i;

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            win_q <= 2'b00;
            fcnt_q <= 16'h0000;
        end else begin
            for (i = 0; i < 2; i = i + 1) begin
                if (raw_win[i] == win_q[i]) begin
                    fcnt_q[i*8 +: 8] <= 8'h00;
                end else if (fcnt_q[i*8 +: 8] == FLT_CYC) begin
                    win_q[i] <= raw_win[i];
                    fcnt_q[i*8 +: 8] <= 8'h00;
                end else begin
                    fcnt_q[i*8 +: 8] <= fcnt_q[i*8 +: 8] + 8'h01;
                end
            end
        end
    end

    // ==========================================================
    // status outputs
    // window flags also sit in the top two bits of the diagnostic byte
    assign halted_out = halted_q;
    assign gate_supply_good_out = ggood_q;
    assign output_one_in_window_out = win_q[1];
    assign output_two_in_window_out = win_q[0];
    assign diagnostic_flags_out = diag;

endmodule

// ==== sim/sdi_chk_sva.sv ====
// concurrent checks on the ports of the serial diagnostic interface
`timescale 1ns/1ns
`include "sdi_defs.vh"
module sdi_chk (
    // clock and reset
    input logic clk_in,
    input logic rst_b_in,
    // watched inputs
    input logic select_n_in,
    input logic supply_over_in,
    input logic supply_under_in,
    input logic overtemp_in,
    input logic off_mode_in,
    input logic config_mode_in,
    // watched outputs
    input logic sdo_oe_b_out,
    input logic reg_wr_out,
    input logic [6:0] reg_addr_out,
    input logic halted_out,
    input logic gate_supply_good_out,
    input logic gate_drive_enable_out,
    input logic [7:0] diagnostic_flags_out
);
    // ==========================================
    // properties
    localparam logic [127:0] CTRL = `SDI_CTRL_MAP;
    localparam logic [127:0] CFG = `SDI_CFG_MAP;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // three samples cover the select synchroniser
    sequence sel_hi; select_n_in [*3]; endsequence
    sequence sel_lo; !select_n_in [*3]; endsequence
    float_out_a: assert property (sel_hi |=> sdo_oe_b_out) else $error("sdo driven while deselected");
    drive_out_a: assert property (sel_lo |=> !sdo_oe_b_out) else $error("sdo not driven in frame");
    ov_set_a: assert property (supply_over_in [*3] |=> diagnostic_flags_out[2] && halted_out)
        else $error("overvoltage not flagged");
    uv_set_a: assert property (supply_under_in [*3] |=> diagnostic_flags_out[3] && halted_out)
        else $error("undervoltage not flagged");
    ot_set_a: assert property (overtemp_in [*3] |=> diagnostic_flags_out[4] && halted_out)
        else $error("overtemperature not flagged");
    halt_keep_a: assert property (halted_out && !off_mode_in |=> halted_out) else $error("halt released");
    off_clear_a: assert property ((off_mode_in && !supply_over_in && !supply_under_in && !overtemp_in) [*4]
        |=> diagnostic_flags_out[4:2] == 3'h0) else $error("off mode kept flags");
    gate_drv_a: assert property (gate_drive_enable_out |-> gate_supply_good_out && !halted_out)
        else $error("gate drive without good supply");
    wr_frame_a: assert property (reg_wr_out |-> $past(select_n_in, 3) && !$past(select_n_in, 4))
        else $error("write outside frame end");
    wr_legal_a: assert property (reg_wr_out |-> CTRL[reg_addr_out] || (CFG[reg_addr_out] && config_mode_in))
        else $error("illegal register write");
endmodule
bind sdi_top sdi_chk u_chk (.*);

// ==== sim/sdi_ctl.sv ====
// controller model driving the serial link
`timescale 1ns/1ns
module sdi_ctl (
    // clock
    input logic clk_in,
    // serial link
    input logic sdo_in,
    input logic sdo_oe_b_in,
    output logic select_n_out,
    output logic sclk_out,
    output logic sdi_out
);
    // ==========================================
    // frame engine
    logic last_q = '0;
    // a released line reads back inverted so a float never looks valid
    wire line = sdo_oe_b_in ? ~last_q : sdo_in;
    always @(posedge clk_in) if (!sdo_oe_b_in) last_q <= sdo_in;
    initial begin
        select_n_out = '1;
        sclk_out = '0;
        sdi_out = '0;
    end
    task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = '0;
        @(negedge clk_in) select_n_out = '0;
        repeat (8) @(negedge clk_in);
        for (int i = n - 1; i >= 0; i--) begin
            sdi_out = tx[i];
            sclk_out = '1;
            repeat (4) @(negedge clk_in);
            // sdo moves after the rising edge, so it is read just before the falling one
            rx[i] = line;
            sclk_out = '0;
            repeat (4) @(negedge clk_in);
        end
        select_n_out = '1;
        sdi_out = ~sdi_out;
        repeat (8) @(negedge clk_in);
    endtask
endmodule

// ==== sim/tb_sdi_top.sv ====
// self-checking testbench for the serial diagnostic interface
`timescale 1ns/1ns
module tb_sdi_top;
    // ==========================================
    // harness
    logic clk_in = '0, rst_b_in = '0, off_m = '0, cfg_m = '0, gwin = '1, grng = '1, o1 = '0;
    logic [2:0] flt = '0;
    logic [6:0] addr;
    logic [7:0] wdat, diag, mem [128];
    logic [31:0] rx;
    wire sel_n, sclk, sdi, sdo, oe_b, wr, halt, ggood, gde, w1, w2;
    int error_cnt = 0, tests_run = 0;
    initial forever #25 clk_in = ~clk_in;
    initial for (int i = 0; i < 128; i++) mem[i] = i[7:0] ^ 8'hA5;
    always @(posedge clk_in) if (wr) mem[addr] <= wdat;
    sdi_top #(.GATE_SETTLE_CYC(16'h0028), .GATE_ERR_CYC(16'h0050)) u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .select_n_in(sel_n), .sclk_in(sclk), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_b_out(oe_b),
        .supply_over_in(flt[0]), .supply_under_in(flt[1]), .overtemp_in(flt[2]),
        .gate_supply_in_window_in(gwin), .gate_supply_in_range_in(grng), .output_one_raw_in(o1),
        .output_two_raw_in(o1), .off_mode_in(off_m), .config_mode_in(cfg_m), .reg_wr_out(wr),
        .reg_addr_out(addr), .reg_wdata_out(wdat), .reg_rdata_in(mem[addr]), .halted_out(halt),
        .gate_supply_good_out(ggood), .gate_drive_enable_out(gde), .output_one_in_window_out(w1),
        .output_two_in_window_out(w2), .diagnostic_flags_out(diag));
    sdi_ctl u_ctl (.clk_in(clk_in), .sdo_in(sdo), .sdo_oe_b_in(oe_b), .select_n_out(sel_n),
        .sclk_out(sclk), .sdi_out(sdi));
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ==========================================
    // scenarios
    task t_rw;
        u_ctl.xfer(16, 32'h0000_5F00, rx);
        chk("first reply", rx, '0);
        u_ctl.xfer(16, 32'h0000_8303, rx);
        chk("clean diag", rx[15:8], 8'h20);
        u_ctl.xfer(16, 32'h0000_035A, rx);
        chk("read data", rx[7:0], 8'hA6);
        u_ctl.xfer(16, 32'h0000_83FF, rx);
        chk("written data", rx[7:0], 8'h5A);
        u_ctl.xfer(16, 32'h0000_8300, rx);
        chk("read keeps", {rx[12:9], rx[7:0]}, 12'h05A);
        $display("t_rw done");
    endtask
    task automatic t_bad;
        logic [31:0] tx [5] = '{32'h0000_41AA, 32'h0000_7FAA, 32'h0000_02AA, 32'h0000_FF00, 32'h0000_0877};
        int n [5] = '{16, 16, 16, 16, 17};
        logic [7:0] b;
        // the odd-length frame still carries address 0x08 in its last sixteen bits
        for (int i = 0; i < 5; i++) begin
            b = mem[tx[i][14:8]];
            u_ctl.xfer(n[i], tx[i], rx);
            u_ctl.xfer(16, 32'h0000_5F00, rx);
            chk("error reply", {rx[9], rx[7:0]}, 9'h100);
            chk("no write", mem[tx[i][14:8]], b);
            u_ctl.xfer(16, 32'h0000_8300, rx);
            chk("error cleared", rx[9], '0);
        end
        @(negedge clk_in) cfg_m = '1;
        u_ctl.xfer(16, 32'h0000_020C, rx);
        u_ctl.xfer(16, 32'h0000_8200, rx);
        chk("config write", rx[7:0], 8'h0C);
        cfg_m = '0;
        $display("t_bad done");
    endtask
    task t_chain;
        u_ctl.xfer(32, 32'h1234_0533, rx);
        chk("chain pass", rx[15:0], 16'h1234);
        chk("chain reply", rx[23:16], 8'h0C);
        chk("chain write", mem[5], 8'h33);
        $display("t_chain done");
    endtask
    task t_flt;
        for (int k = 0; k < 3; k++) begin
            @(negedge clk_in) flt[k] = '1;
            repeat (6) @(negedge clk_in);
            flt[k] = '0;
            chk("fault flag", {halt, diag[k + 2]}, 2'h3);
            u_ctl.xfer(16, 32'h0000_5F00, rx);
            chk("flag cleared", {halt, diag[k + 2]}, 2'h2);
            @(negedge clk_in) off_m = '1;
            repeat (4) @(negedge clk_in);
            off_m = '0;
            u_ctl.xfer(16, 32'h0000_8300, rx);
            chk("after off", {halt, rx[15:0]}, '0);
        end
        $display("t_flt done");
    endtask
    task t_gate;
        @(negedge clk_in) off_m = '1;
        repeat (4) @(negedge clk_in);
        off_m = '0;
        repeat (60) @(negedge clk_in);
        chk("gate good", {ggood, gde, halt}, 3'h6);
        grng = '0;
        gwin = '0;
        repeat (10) @(negedge clk_in);
        chk("out of range", {ggood, gde, halt}, 3'h0);
        gwin = '1;
        repeat (10) @(negedge clk_in);
        chk("good again", {ggood, gde, halt}, 3'h6);
        grng = '1;
        gwin = '0;
        repeat (10) @(negedge clk_in);
        chk("gate lost", {ggood, gde, halt}, 3'h1);
        @(negedge clk_in) gwin = '0;
        off_m = '1;
        repeat (4) @(negedge clk_in);
        off_m = '0;
        repeat (100) @(negedge clk_in);
        chk("gate fault", {halt, diag[0]}, 2'h3);
        gwin = '1;
        o1 = '1;
        repeat (150) @(negedge clk_in);
        chk("window early", {w1, w2}, 2'h0);
        repeat (60) @(negedge clk_in);
        chk("window late", {w1, w2}, 2'h3);
        o1 = '0;
        repeat (150) @(negedge clk_in);
        chk("window held", {w1, w2}, 2'h3);
        repeat (60) @(negedge clk_in);
        chk("window cleared", {w1, w2}, 2'h0);
        $display("t_gate done");
    endtask
    // ==========================================
    // sequence and watchdog
    initial begin
        repeat (2) @(negedge clk_in);
        rst_b_in = '1;
        repeat (4) @(negedge clk_in);
        t_rw;
        t_bad;
        t_chain;
        t_flt;
        t_gate;
        end_sim;
    end
    initial begin
        #1000000;
        error_cnt++;
        end_sim;
    end
endmodule
